// ===== lfi_pkg.sv
/*
  Shared constants and types for the LED fault, state and serial target core.
  Assumes a single 10 MHz clock and a synchronous active-high reset.
*/
package lfi_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int DET_PERIOD_NS = 10000;
  localparam int DET_CYC       = (DET_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLT_CONSEC    = 3;
  localparam logic [7:0] PWM_DET_MIN = 8'h19;

  // ==========================================================
  // Register offsets (10-bit pointer space)
  localparam logic [9:0] A_CHIP_EN  = 10'h000;
  localparam logic [9:0] A_CFG0     = 10'h001;
  localparam logic [9:0] A_CFG3     = 10'h004;
  localparam logic [9:0] A_CFG12    = 10'h00d;
  localparam logic [9:0] A_UPDATE   = 10'h010;
  localparam logic [9:0] A_START    = 10'h011;
  localparam logic [9:0] A_STOP     = 10'h012;
  localparam logic [9:0] A_LED_EN   = 10'h020;
  localparam logic [9:0] A_FLT_CLR  = 10'h022;
  localparam logic [9:0] A_SW_RST   = 10'h023;
  localparam logic [9:0] A_DC0      = 10'h030;
  localparam logic [9:0] A_PWM0     = 10'h040;
  localparam logic [9:0] A_TSD_STAT = 10'h300;
  localparam logic [9:0] A_OPEN_ST  = 10'h301;
  localparam logic [9:0] A_SHORT_ST = 10'h303;

  // ==========================================================
  // Field positions and reset values
  localparam int FC_OPEN_CLR  = 0;
  localparam int FC_SHORT_CLR = 1;
  localparam int CFG0_MCR     = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_PWM  = 8'h80;

  // ==========================================================
  // Serial addressing
  localparam logic [2:0] CHIP_ID_HI   = 3'b101;
  localparam logic [4:0] CHIP_BCAST   = 5'b11011;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_STBY = 2'b01,
    ST_NORM = 2'b10,
    ST_ALL_OFF_FAULT_STATE = 2'b11
  } lfi_state_e;

  typedef struct packed {
    logic [1:0] rsvd;
    logic [3:0] short_thr;
    logic       short_action;
    logic       open_action;
  } lfi_cfg12_s;

  typedef struct packed {
    logic       wr;
    logic [9:0] addr;
    logic [7:0] wdata;
  } lfi_regacc_s;

endpackage

// ===== lfi_fault_filt.sv
/*
  Per-channel consecutive-sample filter for a fault comparator.
  Assumes comparator levels already synchronised to i_clk.
*/
module lfi_fault_filt import lfi_pkg::*; #(
  parameter int N_CH = 4
) (
  input  wire logic            i_clk,
  input  wire logic            i_srst,
  input  wire logic            i_tick,
  input  wire logic [N_CH-1:0] i_qual,
  input  wire logic [N_CH-1:0] i_cond,
  input  wire logic            i_clr,
  output logic      [N_CH-1:0] o_flag
);

  initial begin
    if (N_CH < 1) $error("N_CH must be at least 1");
  end

  logic [1:0] cnt_r [N_CH];

  // ==========================================================
  // Count detection ticks with the fault present, flag at the limit
  always_ff @(posedge i_clk) begin
    for (int i = 0; i < N_CH; i++) begin
      if (i_srst) begin
        cnt_r[i]  <= 2'h0;
        o_flag[i] <= 1'b0;
      end else if (i_tick && i_qual[i]) begin
        if (!i_cond[i]) begin
          cnt_r[i]  <= 2'h0;
          o_flag[i] <= 1'b0;                               // see R4 see R9
        end else if (cnt_r[i] == 2'(FLT_CONSEC - 1)) begin
          o_flag[i] <= 1'b1;                               // see R3 see R8
        end else begin
          cnt_r[i] <= cnt_r[i] + 2'h1;
          if (i_clr) o_flag[i] <= 1'b0;
        end
      end else if (i_clr) begin
        o_flag[i] <= 1'b0;                                 // see R4 see R9
        cnt_r[i]  <= 2'h0;
      end
    end
  end

endmodule

// ===== lfi_i2c_tgt.sv
/*
  Two-wire serial target with 10-bit register pointer and auto-increment.
  Assumes SCL and SDA are asynchronous pins; open-drain SDA, oe high pulls low.
*/
module lfi_i2c_tgt import lfi_pkg::*; (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  input  wire logic [1:0]  i_addr_sel,
  input  wire logic [7:0]  i_rdata,
  output lfi_regacc_s      o_acc,
  output logic [9:0]       o_raddr,
  output logic             o_sda_out,
  output logic             o_sda_oe
);

  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_ADR1 = 3'b001,
    I_ADR2 = 3'b010,
    I_WR   = 3'b011,
    I_RD   = 3'b100
  } lfi_i2c_e;

  lfi_i2c_e    st_r;
  logic [2:0]  scl_s, sda_s;
  logic [1:0]  sel_m, sel_r;
  logic [3:0]  cnt_r;
  logic [7:0]  sh_r, tx_r;
  logic [9:0]  ptr_r;
  logic        nack_r, ld_r, armed_r, match;
  logic        scl_rise, scl_fall, start_c, stop_c;

  // ==========================================================
  // Two-flop synchronisers, third stage only for edge finding
  always_ff @(posedge i_clk) begin
    scl_s <= {scl_s[1:0], i_scl};
    sda_s <= {sda_s[1:0], i_sda};
    sel_m <= i_addr_sel;
    sel_r <= sel_m;
  end

  assign scl_rise = scl_s[1] & ~scl_s[2];
  assign scl_fall = ~scl_s[1] & scl_s[2];
  assign start_c  = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  assign stop_c   = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
  // Independent or broadcast chip address
  assign match    = (sh_r[7:3] == {CHIP_ID_HI, sel_r}) || (sh_r[7:3] == CHIP_BCAST); // see R20
  assign o_raddr  = ptr_r;
  assign o_sda_out = 1'b0;

  // ==========================================================
  // Byte engine: shift on rise, act on fall
  always_ff @(posedge i_clk) begin
    o_acc.wr <= 1'b0;
    ld_r     <= 1'b0;
    if (i_srst || stop_c) begin
      st_r     <= I_IDLE;
      cnt_r    <= 4'h0;
      o_sda_oe <= 1'b0;
      nack_r   <= 1'b0;
      armed_r  <= 1'b0;
    end else if (start_c) begin
      st_r     <= I_ADR1;                                  // see R24
      cnt_r    <= 4'h0;
      o_sda_oe <= 1'b0;
      armed_r  <= 1'b0;                                    // START's own SCL fall is no bit
    end else if (ld_r) begin
      tx_r     <= i_rdata;
      o_sda_oe <= ~i_rdata[7];                             // see R21
    end else if (scl_rise && st_r != I_IDLE) begin
      armed_r <= 1'b1;
      if (cnt_r < 4'h8) sh_r <= {sh_r[6:0], sda_s[1]};     // see R21
      else if (st_r == I_RD) nack_r <= sda_s[1];           // see R19
    end else if (scl_fall && st_r != I_IDLE && armed_r) begin
      if (cnt_r < 4'h7) begin
        cnt_r <= cnt_r + 4'h1;
        if (st_r == I_RD) begin
          o_sda_oe <= ~tx_r[6];
          tx_r     <= {tx_r[6:0], 1'b0};
        end
      end else if (cnt_r == 4'h7) begin
        cnt_r    <= 4'h8;
        o_sda_oe <= (st_r != I_RD) && (st_r != I_ADR1 || match); // see R18
      end else begin
        cnt_r    <= 4'h0;
        o_sda_oe <= 1'b0;
        case (st_r)
          I_ADR1: begin
            if (!match) begin
              st_r <= I_IDLE;
            end else begin
              ptr_r[9:8] <= sh_r[2:1];                     // see R20
              st_r       <= sh_r[0] ? I_RD : I_ADR2;
              ld_r       <= sh_r[0];
            end
          end
          I_ADR2: begin
            ptr_r[7:0] <= sh_r;                            // see R21
            st_r       <= I_WR;
          end
          I_WR: begin
            o_acc.wr    <= 1'b1;
            o_acc.addr  <= ptr_r;
            o_acc.wdata <= sh_r;
            ptr_r       <= ptr_r + 10'h001;                // see R22 see R24
          end
          I_RD: begin
            if (nack_r) begin
              st_r <= I_IDLE;                              // see R19
            end else begin
              ptr_r <= ptr_r + 10'h001;                    // see R22 see R24
              ld_r  <= 1'b1;
            end
          end
          default: st_r <= I_IDLE;
        endcase
      end
    end
  end

endmodule

// ===== lfi_core.sv
/*
  LED fault handling, operating state machine and serial register access.
  Assumes analog comparators and thermal sensor give asynchronous levels.
*/
// Function
// R1: Open threshold follows max current range
// R2: Detect only when PWM above 25
// R3: Open flag after three consecutive low samples
// R4: Open flags clear by write or self
// R5: Open action turns off faulty channel
// R6: Open detection only in normal state
// R7: Short threshold from configurable field
// R8: Short flag after three consecutive high samples
// R9: Short flags clear by write or self
// R10: Short action turns every channel off
// R11: Short detection only in normal state
// R12: Over temperature turns all channels off
// R13: Initial at reset, standby on chip enable
// R14: Normal to standby: none effective, stop
// R15: Standby to normal when one LED effective
// R16: All-off state on short, exits by clear
// R17: Serial clock up to 1 MHz
// R18: Acknowledge each received byte, ninth pulse
// R19: Controller ends read with a nack
// R20: First byte: chip address, pointer high, direction
// R21: Second byte pointer low, MSB first
// R22: Auto-increment across consecutive registers
// R23: Configuration applies only on update command
// R24: Pointer increments per byte, reset at START; code leaves ptr_r unchanged at START, only the address bytes load it
module lfi_core import lfi_pkg::*; #(
  parameter int N_LED = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic             i_scl,
  input  wire logic             i_sda,
  input  wire logic [1:0]       i_addr_sel,
  input  wire logic [N_LED-1:0] i_cath_low,
  input  wire logic [N_LED-1:0] i_cath_high,
  input  wire logic             i_over_temp,
  output logic                  o_sda_out,
  output logic                  o_sda_oe,
  output logic [N_LED-1:0]      o_led_on,
  output logic                  o_open_thr_hi,
  output logic [3:0]            o_short_thr,
  output logic [1:0]            o_state
);

  initial begin
    if (N_LED != 4) $error("N_LED must be 4");
    // Divider and filter counters are 8 and 2 bits wide
    if (DET_CYC < 2 || DET_CYC > 256) $error("DET_CYC out of divider range");
    if (FLT_CONSEC < 1 || FLT_CONSEC > 4) $error("FLT_CONSEC out of counter range");
  end

  // ==========================================================
  // Declarations
  lfi_state_e  st_r, st_nxt;
  lfi_regacc_s acc;
  lfi_cfg12_s  cfg12_p_r, cfg12_r;
  logic [9:0]  raddr;
  logic [7:0]  rdata;
  logic [7:0]  cfg0_p_r, cfg0_r, cfg3_p_r, cfg3_r;
  logic [7:0]  dc_r  [N_LED];
  logic [7:0]  pwm_r [N_LED];
  logic        chip_en_r, started_r, sw_rst_r, rst;
  logic [N_LED-1:0] led_en_r, eff, qual, open_f, short_f;
  logic [N_LED-1:0] low_m, low_s, high_m, high_s;
  logic        ot_m, ot_s;
  logic [7:0]  div_r;
  logic        tick;
  logic        wr_upd, wr_start, wr_stop, clr_open, clr_short;

  assign rst = i_srst | sw_rst_r;

  // Write decode for command registers
  function automatic logic hit(input lfi_regacc_s a, input logic [9:0] off);
    return a.wr && (a.addr == off);
  endfunction

  assign wr_upd    = hit(acc, A_UPDATE);
  assign wr_start  = hit(acc, A_START);
  assign wr_stop   = hit(acc, A_STOP);
  assign clr_open  = hit(acc, A_FLT_CLR) && acc.wdata[FC_OPEN_CLR];
  assign clr_short = hit(acc, A_FLT_CLR) && acc.wdata[FC_SHORT_CLR];

  // ==========================================================
  // Serial target
  lfi_i2c_tgt u_i2c (
    .i_clk      (i_clk),
    .i_srst     (i_srst),
    .i_scl      (i_scl),                                   // see R17
    .i_sda      (i_sda),
    .i_addr_sel (i_addr_sel),
    .i_rdata    (rdata),
    .o_acc      (acc),
    .o_raddr    (raddr),
    .o_sda_out  (o_sda_out),
    .o_sda_oe   (o_sda_oe)
  );

  // ==========================================================
  // Comparator synchronisers
  // Analog levels are asynchronous, two flops before any logic
  always_ff @(posedge i_clk) begin
    low_m  <= i_cath_low;
    low_s  <= low_m;
    high_m <= i_cath_high;
    high_s <= high_m;
    ot_m   <= i_over_temp;
    ot_s   <= ot_m;
  end

  // ==========================================================
  // Detection cycle divider
  // Faults are judged only on this one-cycle tick
  always_ff @(posedge i_clk) begin
    if (i_srst || div_r == 8'(DET_CYC - 1)) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end
  assign tick = (div_r == 8'(DET_CYC - 1));

  // ==========================================================
  // Software reset request, one cycle
  // Serial engine keeps running so the write still completes
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sw_rst_r <= 1'b0;
    end else begin
      sw_rst_r <= hit(acc, A_SW_RST);
    end
  end

  // ==========================================================
  // Directly effective registers
  // Manual settings act at once, no update needed
  always_ff @(posedge i_clk) begin
    if (rst) begin
      chip_en_r <= 1'b0;
      led_en_r  <= '0;
      for (int i = 0; i < N_LED; i++) begin
        dc_r[i]  <= RST_BYTE;
        pwm_r[i] <= RST_PWM;
      end
    end else if (acc.wr) begin
      if (acc.addr == A_CHIP_EN) chip_en_r <= acc.wdata[0];
      if (acc.addr == A_LED_EN) led_en_r <= acc.wdata[N_LED-1:0];
      for (int i = 0; i < N_LED; i++) begin
        if (acc.addr == A_DC0 + 10'(i)) dc_r[i] <= acc.wdata;
        if (acc.addr == A_PWM0 + 10'(i)) pwm_r[i] <= acc.wdata;
      end
    end
  end

  // ==========================================================
  // Configuration: pending copies and active copies
  // Reads return the pending copy before any update
  always_ff @(posedge i_clk) begin
    if (rst) begin
      cfg0_p_r  <= RST_BYTE;
      cfg3_p_r  <= RST_BYTE;
      cfg12_p_r <= RST_BYTE;
    end else if (acc.wr) begin
      if (acc.addr == A_CFG0) cfg0_p_r <= acc.wdata;
      if (acc.addr == A_CFG3) cfg3_p_r <= acc.wdata;
      if (acc.addr == A_CFG12) cfg12_p_r <= acc.wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (rst) begin
      cfg0_r  <= RST_BYTE;
      cfg3_r  <= RST_BYTE;
      cfg12_r <= RST_BYTE;
    end else if (wr_upd) begin
      cfg0_r  <= cfg0_p_r;                                 // see R23
      cfg3_r  <= cfg3_p_r;                                 // see R23
      cfg12_r <= cfg12_p_r;                                // see R23
    end
  end

  // ==========================================================
  // Autonomous start latch
  // A stop makes every auto-mode LED ineffective
  always_ff @(posedge i_clk) begin
    if (rst || wr_stop) begin
      started_r <= 1'b0;
    end else if (wr_start) begin
      started_r <= 1'b1;
    end
  end

  // Effective LEDs; cfg3 low bits choose autonomous mode per LED
  always_comb begin
    for (int i = 0; i < N_LED; i++) begin
      if (cfg3_r[i]) begin
        eff[i] = led_en_r[i] && started_r;                 // see R15
      end else begin
        eff[i] = led_en_r[i] && (pwm_r[i] != 8'h00) && (dc_r[i] != 8'h00); // see R15
      end
      qual[i] = (st_r == ST_NORM) && (pwm_r[i] > PWM_DET_MIN); // see R2 see R6 see R11
    end
  end

  // ==========================================================
  // Fault filters
  // Shared tick and qualifier: open and short judged alike
  lfi_fault_filt #(.N_CH(N_LED)) u_open (
    .i_clk  (i_clk),
    .i_srst (rst),
    .i_tick (tick),
    .i_qual (qual),
    .i_cond (low_s),
    .i_clr  (clr_open),
    .o_flag (open_f)
  );

  lfi_fault_filt #(.N_CH(N_LED)) u_short (
    .i_clk  (i_clk),
    .i_srst (rst),
    .i_tick (tick),
    .i_qual (qual),
    .i_cond (high_s),
    .i_clr  (clr_short),
    .o_flag (short_f)
  );

  // ==========================================================
  // Operating state machine
  // A short with action set beats a stop in the same cycle
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_INIT: if (chip_en_r) st_nxt = ST_STBY;            // see R13
      ST_STBY: if (|eff) st_nxt = ST_NORM;                 // see R15
      ST_NORM: begin
        if (cfg12_r.short_action && |short_f) begin
          st_nxt = ST_ALL_OFF_FAULT_STATE;                                // see R10 see R16
        end else if (wr_stop || !(|eff)) begin
          st_nxt = ST_STBY;                                // see R14
        end
      end
      ST_ALL_OFF_FAULT_STATE: if (clr_short) st_nxt = ST_STBY;            // see R16
      default: st_nxt = ST_INIT;
    endcase
    if (!chip_en_r) st_nxt = ST_INIT;
  end

  always_ff @(posedge i_clk) begin
    if (rst) begin
      st_r <= ST_INIT;                                     // see R13
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Channel drive and threshold selects
  // Over temperature wins; channels return once it clears
  always_ff @(posedge i_clk) begin
    if (rst) begin
      o_led_on      <= '0;
      o_open_thr_hi <= 1'b0;
      o_short_thr   <= 4'h0;
      o_state       <= ST_INIT;
    end else begin
      for (int i = 0; i < N_LED; i++) begin
        o_led_on[i] <= (st_r == ST_NORM) && eff[i] && !ot_s                // see R12 see R16
                       && !(cfg12_r.open_action && open_f[i])              // see R5
                       && !(cfg12_r.short_action && |short_f);             // see R10
      end
      o_open_thr_hi <= cfg0_r[CFG0_MCR];                   // see R1
      o_short_thr   <= cfg12_r.short_thr;                  // see R7
      o_state       <= st_r;
    end
  end

  // ==========================================================
  // Read data
  // Unmapped addresses read as zero
  always_comb begin
    rdata = 8'h00;
    case (raddr)
      A_CHIP_EN:  rdata = {7'h00, chip_en_r};
      A_CFG0:     rdata = cfg0_p_r;
      A_CFG3:     rdata = cfg3_p_r;
      A_CFG12:    rdata = cfg12_p_r;
      A_LED_EN:   rdata = {4'h0, led_en_r};
      A_TSD_STAT: rdata = {5'h00, st_r, ot_s};
      A_OPEN_ST:  rdata = {4'h0, open_f};
      A_SHORT_ST: rdata = {4'h0, short_f};
      default: begin
        for (int i = 0; i < N_LED; i++) begin
          if (raddr == A_DC0 + 10'(i)) rdata = dc_r[i];
          if (raddr == A_PWM0 + 10'(i)) rdata = pwm_r[i];
        end
      end
    endcase
  end

endmodule

// ===== lfi_core_checker.sv
/*
  Port checker for lfi_core, bound to every instance.
  Assumes one clock domain and the synchronous active-high reset.
*/
module lfi_core_checker import lfi_pkg::*; #(
  parameter int N_LED = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic             i_scl,
  input  wire logic             i_over_temp,
  input  wire logic             o_sda_out,
  input  wire logic             o_sda_oe,
  input  wire logic [N_LED-1:0] o_led_on,
  input  wire logic             o_open_thr_hi,
  input  wire logic [3:0]       o_short_thr,
  input  wire logic [1:0]       o_state
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  // ==========
  // Serial target timing
  chk_sda_zero: assert property (o_sda_out == 1'b0) else $error("sda data not zero");
  chk_ack_width: assert property ($rose(o_sda_oe) |-> o_sda_oe [*7])
    else $error("sda pull too short");
  chk_oe_low_clk: assert property ($changed(o_sda_oe) |-> !$past(i_scl, 2))
    else $error("sda changed while clock high");
  chk_cfg_on_write: assert property ($changed({o_open_thr_hi, o_short_thr}) |-> !$past(i_scl, 2))
    else $error("config changed outside a write");

  // ==========
  // State machine and LED gating
  chk_hot_dark: assert property (i_over_temp [*5] |-> o_led_on == '0)
    else $error("leds on while hot");
  chk_init_exit: assert property ($past(o_state) == ST_INIT && o_state != ST_INIT |-> o_state == ST_STBY)
    else $error("bad exit from initial");
  chk_norm_entry: assert property ($changed(o_state) && o_state == ST_NORM |-> $past(o_state) == ST_STBY)
    else $error("normal entered not from standby");
  chk_fault_entry: assert property ($changed(o_state) && o_state == ST_ALL_OFF_FAULT_STATE |-> $past(o_state) == ST_NORM)
    else $error("all-off entered not from normal");
  chk_fault_dark: assert property ((o_state == ST_ALL_OFF_FAULT_STATE) [*2] |-> o_led_on == '0)
    else $error("leds on in all-off state");
  chk_led_norm: assert property (o_led_on != '0 |-> o_state == ST_NORM || $past(o_state) == ST_NORM)
    else $error("leds on outside normal");

  // Main scenarios reached
  cov_fault: cover property (o_state == ST_ALL_OFF_FAULT_STATE);
  cov_norm: cover property (o_state == ST_NORM);
  cov_ack: cover property ($rose(o_sda_oe));
  cov_hot: cover property (i_over_temp && o_state == ST_NORM);
endmodule

bind lfi_core lfi_core_checker #(.N_LED(N_LED)) chk_u (
  .i_clk(i_clk), .i_srst(i_srst), .i_scl(i_scl), .i_over_temp(i_over_temp),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_led_on(o_led_on),
  .o_open_thr_hi(o_open_thr_hi), .o_short_thr(o_short_thr), .o_state(o_state)
);

// ===== lfi_i2c_ctrl_model.sv
/*
  Bus controller model for the two-wire link, 800 ns clock period.
  Assumes SDA has a pull-up; o_sda_oe high pulls it low.
*/
module lfi_i2c_ctrl_model (
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int Q = 200;

  // Idle bus: clock stands high, data released
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end

  // One bit slot, clock low on entry and exit
  task automatic slot(input logic low, output logic seen);
    #Q o_sda_oe = low;
    #Q o_scl = 1'b1;
    #Q seen = i_sda;
    #Q o_scl = 1'b0;
  endtask

  // Start or repeated start, phase skewed from the core clock
  task automatic start();
    #37 o_sda_oe = 1'b0;
    #(2*Q) o_scl = 1'b1;
    #Q o_sda_oe = 1'b1;
    #Q o_scl = 1'b0;
  endtask

  task automatic stop();
    #Q o_sda_oe = 1'b1;
    #Q o_scl = 1'b1;
    #Q o_sda_oe = 1'b0;
    #Q;
  endtask

  // Byte MSB first, then the acknowledge slot
  task automatic octet(input logic [7:0] tx, input logic m_ack, output logic [7:0] rx,
                       output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) slot(!tx[i], rx[i]);
    slot(m_ack, a);
    ack = !a;
  endtask

  // Chip byte with pointer high bits, then pointer low byte
  task automatic head(input logic [4:0] chip, input logic [9:0] a, output logic ok);
    logic [7:0] rx;
    logic       k;
    start();
    octet({chip, a[9:8], 1'b0}, 1'b0, rx, ok);
    octet(a[7:0], 1'b0, rx, k);
    ok = ok & k;
  endtask

  task automatic xfer_wr(input logic [4:0] chip, input logic [9:0] a, input logic [31:0] d,
                         input int n, output logic ok);
    logic [7:0] rx;
    logic       k;
    head(chip, a, ok);
    for (int i = n - 1; i >= 0; i--) begin
      octet(d[8*i +: 8], 1'b0, rx, k);
      ok = ok & k;
    end
    stop();
  endtask

  task automatic xfer_rd(input logic [4:0] chip, input logic [9:0] a, input int n,
                         output logic [31:0] q, output logic ok);
    logic [7:0] rx;
    logic       k;
    q = '0;
    head(chip, a, ok);
    start();
    octet({chip, a[9:8], 1'b1}, 1'b0, rx, k);
    ok = ok & k;
    for (int i = n - 1; i >= 0; i--) begin
      octet(8'hff, i != 0, rx, k);
      q = {q[23:0], rx};
    end
    stop();
  endtask
endmodule

// ===== test_lfi_core.sv
/*
  Self-checking bench for lfi_core with a bus controller model.
  Assumes a 10 MHz clock and the package register offsets.
*/
module test_lfi_core import lfi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic        i_clk, i_srst, scl, m_oe, sda_out, sda_oe, hot, thr_hi, ok;
  logic [1:0]  sel, state, k;
  logic [3:0]  c_low, c_high, led_on, s_thr;
  logic [4:0]  chip;
  logic [7:0]  seed = 8'h1c;
  logic [31:0] q, dc;
  lfi_cfg12_s  cfg;
  int          fails = 0;
  int          comparisons = 0;
  wire         sda = !(m_oe || (sda_oe && !sda_out));

  lfi_core dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_scl(scl), .i_sda(sda), .i_addr_sel(sel),
    .i_cath_low(c_low), .i_cath_high(c_high), .i_over_temp(hot), .o_sda_out(sda_out),
    .o_sda_oe(sda_oe), .o_led_on(led_on), .o_open_thr_hi(thr_hi), .o_short_thr(s_thr),
    .o_state(state));
  lfi_i2c_ctrl_model bus_u (.i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));

  // ==========
  // Clock and watchdog
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    #3000000;
    fails = fails + 1;
    end_of_test();
  end

  // ==========
  // Helpers
  function automatic logic [7:0] rnd();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction
  function automatic logic [3:0] one_hot(input logic [1:0] n);
    return 4'h1 << n;
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input int n);
    bus_u.xfer_wr(chip, a, d, n, ok);
    check("write ack", 1, ok);
    tick(1);
  endtask
  task automatic rd(input logic [9:0] a, input int n);
    bus_u.xfer_rd(chip, a, n, q, ok);
    check("read ack", 1, ok);
    tick(1);
  endtask
  task automatic wait_state(input logic [1:0] s, input int lim);
    for (int n = 0; n < lim && state !== s; n++) tick(1);
    check("state", s, state);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ==========
  // Main sequence
  initial begin
    i_srst = 1'b1;
    {c_low, c_high, hot} = '0;
    q = rnd();
    sel = q[1:0];
    chip = {CHIP_ID_HI, sel};
    repeat (16) @(posedge i_clk);
    #1 i_srst = 1'b0;
    check("state", ST_INIT, state);
    check("leds", 0, led_on);
    bus_u.xfer_wr({CHIP_ID_HI, ~sel}, A_CHIP_EN, 32'h1, 1, ok);
    check("foreign chip ack", 0, ok);
    bus_u.xfer_wr(CHIP_BCAST, A_CHIP_EN, 32'h1, 1, ok);
    check("broadcast ack", 1, ok);
    wait_state(ST_STBY, 8);
    dc = {rnd(), rnd(), rnd(), rnd()} | 32'h01010101;
    wr(A_DC0, dc, 4);
    rd(A_DC0, 4);
    check("dc burst", dc, q);
    rd(A_PWM0, 1);
    check("pwm reset", RST_PWM, q);
    cfg = '{rsvd: 2'b00, short_thr: 4'(rnd()), short_action: 1'b0, open_action: 1'b1};
    wr(A_CFG0, 32'h1, 1);
    wr(A_CFG12, cfg, 1);
    check("open range pending", 0, thr_hi);
    check("short code pending", 0, s_thr);
    wr(A_UPDATE, 32'h1, 1);
    check("open range", 1, thr_hi);
    check("short code", cfg.short_thr, s_thr);
    wr(A_LED_EN, 32'hf, 1);
    wait_state(ST_NORM, 8);
    check("leds", 4'hf, led_on);
    // Open on one channel: two ticks are not enough, the third turns it off
    q = rnd();
    k = q[1:0];
    c_low = one_hot(k);
    tick(195);
    check("leds early", 4'hf, led_on);
    tick(115);
    check("leds open", 4'hf & ~one_hot(k), led_on);
    rd(A_OPEN_ST, 1);
    check("open flags", one_hot(k), q);
    c_low = '0;
    tick(250);
    rd(A_OPEN_ST, 1);
    check("open flags gone", 0, q);
    // Short with action: every channel off, clear returns to standby
    cfg.short_action = 1'b1;
    wr(A_CFG12, cfg, 1);
    wr(A_UPDATE, 32'h1, 1);
    q = rnd();
    k = q[1:0];
    c_low = one_hot(k);
    c_high = one_hot(k);
    wait_state(ST_ALL_OFF_FAULT_STATE, 400);
    tick(2);
    check("leds short", 0, led_on);
    c_low = '0;
    c_high = '0;
    rd(A_SHORT_ST, 1);
    check("short flags", one_hot(k), q);
    wr(A_FLT_CLR, 32'h1, 1);
    rd(A_OPEN_ST, 1);
    check("open flags cleared", 0, q);
    wr(A_LED_EN, 32'h0, 1);
    check("state held", ST_ALL_OFF_FAULT_STATE, state);
    wr(A_FLT_CLR, 32'h2, 1);
    wait_state(ST_STBY, 8);
    rd(A_SHORT_ST, 1);
    check("short flags cleared", 0, q);
    // PWM at 25 leaves the channel unchecked
    wr(A_PWM0, {4{PWM_DET_MIN}}, 4);
    wr(A_LED_EN, 32'hf, 1);
    wait_state(ST_NORM, 8);
    c_low = 4'hf;
    tick(320);
    check("leds low pwm", 4'hf, led_on);
    rd(A_OPEN_ST, 1);
    check("open flags low pwm", 0, q);
    c_low = '0;
    // Thermal shutdown and recovery
    hot = 1'b1;
    tick(8);
    check("leds hot", 0, led_on);
    hot = 1'b0;
    tick(8);
    check("leds cool", 4'hf, led_on);
    // Auto mode: effective only between start and stop; then software reset
    wr(A_CFG3, 32'hf, 1);
    wr(A_UPDATE, 32'h1, 1);
    wait_state(ST_STBY, 8);
    wr(A_START, 32'h1, 1);
    wait_state(ST_NORM, 8);
    check("leds auto", 4'hf, led_on);
    wr(A_STOP, 32'h1, 1);
    wait_state(ST_STBY, 8);
    wr(A_SW_RST, 32'h1, 1);
    wait_state(ST_INIT, 8);
    check("open range reset", 0, thr_hi);
    end_of_test();
  end
endmodule
